// *** src/synchrocheck_pkg.sv ***
// Constants shared by the synchrocheck control block and its timer.
// Assumes a 100 MHz system clock and an AXI4-Lite register master.
package synchrocheck_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int TICK_TIME_US = 5000;
  localparam int TICK_CYCLES = TICK_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int TIME_STEP_MS = 5;
  localparam int BRK_DELAY_DEFAULT_MS = 50;
  localparam int TIME_W = 17;
  localparam int DELAY_W = 19;
  localparam logic [DELAY_W-1:0] BRK_DELAY_RESET =
    DELAY_W'(BRK_DELAY_DEFAULT_MS / TIME_STEP_MS);
  localparam logic [TIME_W-1:0] TIME_MAX = 17'h11940;
  localparam int ANGLE_W = 20;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_OFFSET = 8'h00;
  localparam logic [7:0] BRK_DELAY_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] EST_CLOSE_OFFSET = 8'h0C;
  localparam logic [7:0] ROT_TIME_OFFSET = 8'h10;
  localparam logic [7:0] ANGLE_OFFSET = 8'h14;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  localparam int CFG_FORCE_EN_BIT = 0;
  localparam int CFG_FORCE_SEL_LSB = 1;
  localparam int CFG_LINE_REF_BIT = 4;
  localparam int CFG_STAGE_EN_LSB = 5;
  localparam int CFG_START_LSB = 8;
  localparam int CFG_REF1_LSB = 11;
  localparam int CFG_REF2_LSB = 14;
  localparam int CFG_REF3_BIT = 16;
  localparam int CFG_AUTO_BIT = 17;
  localparam int CFG_OBJ_LSB = 18;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] CONFIG_MASK = 32'h001F_FFFF;

  // Status fields
  localparam int STS_MATCH_LSB = 0;
  localparam int STS_BLOCKED_LSB = 3;
  localparam int STS_ACCESS_BIT = 6;
  localparam int STS_ACTIVE_LSB = 7;
  localparam int STS_CLOSED_BIT = 10;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FORCE_NORMAL = 3'h0,
    FORCE_S1_BLOCKED = 3'h1,
    FORCE_S1_OK = 3'h2,
    FORCE_S2_BLOCKED = 3'h3,
    FORCE_S2_OK = 3'h4,
    FORCE_S3_BLOCKED = 3'h5,
    FORCE_S3_OK = 3'h6
  } force_sel_t;

  localparam logic [2:0] REF1_NOT_IN_USE = 3'h0;
  localparam logic [2:0] REF1_LAST_LL = 3'h3;
  localparam logic [2:0] REF1_LAST = 3'h6;
  localparam logic [1:0] REF2_NOT_IN_USE = 2'h0;
  localparam int STAGES = 3;
  localparam int OBJECTS = 5;
  localparam logic [2:0] OBJ_LAST = 3'h4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** src/sync_rotation_timer.sv ***
// Slip timer: measures one full relative rotation and the time left.
// Assumes a program-cycle tick of one clock and a signed angle input.
`timescale 1ns/10ps
module sync_rotation_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [synchrocheck_pkg::ANGLE_W-1:0] angle,
  output logic [synchrocheck_pkg::TIME_W-1:0] rot_time,
  output logic [synchrocheck_pkg::TIME_W-1:0] est_time
);

  typedef struct packed {
    logic prev_neg;
    logic [synchrocheck_pkg::TIME_W-1:0] elapsed;
    logic [synchrocheck_pkg::TIME_W-1:0] rot;
    logic [synchrocheck_pkg::TIME_W-1:0] est;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;

  // ----------------------------------------------------------------
  // Rotation measurement
  // ----------------------------------------------------------------
  always_comb begin
    logic neg;
    neg = angle[synchrocheck_pkg::ANGLE_W-1];
    state_next = state_reg;
    if (tick) begin
      state_next.prev_neg = neg;
      // Crossing of the relative angle from negative to non-negative closes one rotation
      if (state_reg.prev_neg && !neg) begin
        state_next.rot = state_reg.elapsed;
        state_next.elapsed = 17'h00001;
      end else if (state_reg.elapsed != synchrocheck_pkg::TIME_MAX) begin
        state_next.elapsed = state_reg.elapsed + 17'h00001;
      end
      if (state_next.rot > state_next.elapsed) begin
        state_next.est = state_next.rot - state_next.elapsed;
      end else begin
        state_next.est = 17'h00000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rot_time = state_reg.rot;
  assign est_time = state_reg.est;

endmodule

// *** src/synchrocheck_control.sv ***
// Synchrocheck blocking, forcing, stage gating and auto-close control.
// Assumes comparison logic and blocking matrix on the same clock, an
// asynchronous begin input per stage and an AXI4-Lite master.
`timescale 1ns/10ps
module synchrocheck_control #(
  parameter int TICK_CYCLES = synchrocheck_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  // Comparison and blocking inputs, same clock
  input wire logic [2:0] sync_ok_in,
  input wire logic [2:0] block_in,
  input wire logic [synchrocheck_pkg::ANGLE_W-1:0] angle_diff,
  // Voltage channel configuration, same clock
  input wire logic third_voltage_input,
  input wire logic fourth_voltage_input,
  input wire logic ll_only_wiring,
  input wire logic two_ll_aux_wiring,
  // Start inputs from pins
  input wire logic [2:0] stage_begin_input,
  // Function outputs
  output logic [2:0] match_confirmed,
  output logic [2:0] blocked,
  output logic [4:0] close_command,
  output logic line_is_measured,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [31:0] tick_cnt;
    logic tick;
    logic [2:0] begin_meta;
    logic [2:0] begin_sync;
    logic [31:0] cfg;
    logic [synchrocheck_pkg::DELAY_W-1:0] brk_delay;
    logic [synchrocheck_pkg::ANGLE_W-1:0] angle;
    logic [2:0] match;
    logic [2:0] blk;
    logic [2:0] done;
    logic [2:0] match_out;
    logic [2:0] blk_out;
    logic close_done;
    logic [4:0] close_cmd;
    logic line_ref;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } ctrl_state_t;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;

  logic [synchrocheck_pkg::TIME_W-1:0] rot_time;
  logic [synchrocheck_pkg::TIME_W-1:0] est_time;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  logic access_ok;
  logic both_aux;
  logic force_en;
  logic [2:0] force_sel;
  logic [2:0] stage_en;
  logic [2:0] start_on_begin;
  logic [2:0] ref1;
  logic [1:0] ref2;
  logic ref3;
  logic auto_close;
  logic [2:0] obj_sel;
  logic [2:0] active;
  logic [2:0] cond;
  logic [2:0] force_blk;
  logic [2:0] force_ok;

  assign access_ok = third_voltage_input | fourth_voltage_input;
  assign both_aux = third_voltage_input & fourth_voltage_input;
  assign force_en = state_reg.cfg[synchrocheck_pkg::CFG_FORCE_EN_BIT];
  assign force_sel = state_reg.cfg[synchrocheck_pkg::CFG_FORCE_SEL_LSB +: 3];
  assign stage_en = state_reg.cfg[synchrocheck_pkg::CFG_STAGE_EN_LSB +: 3];
  assign start_on_begin = state_reg.cfg[synchrocheck_pkg::CFG_START_LSB +: 3];
  assign ref1 = state_reg.cfg[synchrocheck_pkg::CFG_REF1_LSB +: 3];
  assign ref2 = state_reg.cfg[synchrocheck_pkg::CFG_REF2_LSB +: 2];
  assign ref3 = state_reg.cfg[synchrocheck_pkg::CFG_REF3_BIT];
  assign auto_close = state_reg.cfg[synchrocheck_pkg::CFG_AUTO_BIT];
  assign obj_sel = state_reg.cfg[synchrocheck_pkg::CFG_OBJ_LSB +: 3];

  // Stage one: third channel, or the single check channel
  assign active[0] = stage_en[0] && access_ok &&
    ref1 != synchrocheck_pkg::REF1_NOT_IN_USE &&
    ref1 <= synchrocheck_pkg::REF1_LAST &&
    (!ll_only_wiring || ref1 <= synchrocheck_pkg::REF1_LAST_LL);
  // Stage two: fourth channel against line-to-line reference
  assign active[1] = stage_en[1] && both_aux &&
    ref2 != synchrocheck_pkg::REF2_NOT_IN_USE;
  // Stage three: third channel against fourth channel
  assign active[2] = stage_en[2] && both_aux && ref3 &&
    two_ll_aux_wiring;

  // ----------------------------------------------------------------
  // Per-stage qualification and forcing
  // ----------------------------------------------------------------
  for (genvar i = 0; i < synchrocheck_pkg::STAGES; i++) begin : g_stage
    assign cond[i] = active[i] && sync_ok_in[i] &&
      (!start_on_begin[i] || state_reg.begin_sync[i]);
    assign force_blk[i] = force_en &&
      force_sel == 3'(2 * i + 1);
    assign force_ok[i] = force_en &&
      force_sel == 3'(2 * i + 2);
  end

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] merged;
    logic [31:0] rd;
    logic hit;
    merged = 32'h0000_0000;
    rd = 32'h0000_0000;
    hit = 1'b0;
    state_next = state_reg;

    state_next.begin_meta = stage_begin_input;
    state_next.begin_sync = state_reg.begin_meta;

    // Program cycle divider
    if (state_reg.tick_cnt == 32'(TICK_CYCLES - 1)) begin
      state_next.tick_cnt = 32'h0000_0000;
      state_next.tick = 1'b1;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + 32'h0000_0001;
      state_next.tick = 1'b0;
    end

    state_next.close_cmd = 5'h00;
    if (state_reg.tick) begin
      state_next.angle = angle_diff;
      state_next.line_ref =
        state_reg.cfg[synchrocheck_pkg::CFG_LINE_REF_BIT];
      for (int i = 0; i < synchrocheck_pkg::STAGES; i++) begin
        // Blocking read from the matrix input before a match and each program cycle while matched
        if (!cond[i]) begin
          state_next.match[i] = 1'b0;
          state_next.blk[i] = 1'b0;
          state_next.done[i] = 1'b0;
        end else if (state_reg.match[i]) begin
          if (block_in[i]) begin
            state_next.match[i] = 1'b0;
            state_next.done[i] = 1'b1;
          end
        end else if (!state_reg.done[i]) begin
          if (block_in[i]) begin
            state_next.blk[i] = 1'b1;
            state_next.done[i] = 1'b1;
          end else begin
            state_next.match[i] = 1'b1;
          end
        end
        state_next.match_out[i] =
          force_ok[i] || (!force_blk[i] && state_next.match[i]);
        state_next.blk_out[i] =
          force_blk[i] || (!force_ok[i] && state_next.blk[i]);
      end

      // Auto close on stage one, advanced by the breaker delay
      if (!state_next.match[0]) begin
        state_next.close_done = 1'b0;
      end else if (auto_close && active[0] && !state_reg.close_done &&
          {2'b00, est_time} <= state_reg.brk_delay) begin
        state_next.close_done = 1'b1;
        if (obj_sel <= synchrocheck_pkg::OBJ_LAST) begin
          state_next.close_cmd = 5'(5'h01 << obj_sel);
        end else begin
          state_next.close_cmd = 5'h01;
        end
      end
    end

    // Write channel: address and data taken together
    if (state_reg.awready) begin
      state_next.awready = 1'b0;
      state_next.wready = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = synchrocheck_pkg::RESP_OKAY;
      unique case (s_axi_awaddr)
        synchrocheck_pkg::CONFIG_OFFSET: begin
          if (access_ok) begin
            merged = merge_bytes(state_reg.cfg, s_axi_wdata, s_axi_wstrb);
            state_next.cfg = merged & synchrocheck_pkg::CONFIG_MASK;
          end else begin
            state_next.bresp = synchrocheck_pkg::RESP_SLVERR;
          end
        end
        synchrocheck_pkg::BRK_DELAY_OFFSET: begin
          if (access_ok) begin
            merged = merge_bytes({13'h0000, state_reg.brk_delay},
              s_axi_wdata, s_axi_wstrb);
            state_next.brk_delay =
              merged[synchrocheck_pkg::DELAY_W-1:0];
          end else begin
            state_next.bresp = synchrocheck_pkg::RESP_SLVERR;
          end
        end
        default: begin
          state_next.bresp = synchrocheck_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_awvalid && s_axi_wvalid && !state_reg.bvalid) begin
      state_next.awready = 1'b1;
      state_next.wready = 1'b1;
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // Read channel
    if (state_reg.arready) begin
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      hit = 1'b1;
      case (s_axi_araddr)
        synchrocheck_pkg::CONFIG_OFFSET: begin
          rd = state_reg.cfg;
        end
        synchrocheck_pkg::BRK_DELAY_OFFSET: begin
          rd = {13'h0000, state_reg.brk_delay};
        end
        synchrocheck_pkg::STATUS_OFFSET: begin
          rd[synchrocheck_pkg::STS_MATCH_LSB +: 3] = state_reg.match_out;
          rd[synchrocheck_pkg::STS_BLOCKED_LSB +: 3] = state_reg.blk_out;
          rd[synchrocheck_pkg::STS_ACCESS_BIT] = access_ok;
          rd[synchrocheck_pkg::STS_ACTIVE_LSB +: 3] = active;
          rd[synchrocheck_pkg::STS_CLOSED_BIT] = state_reg.close_done;
        end
        synchrocheck_pkg::EST_CLOSE_OFFSET: begin
          rd = {15'h0000, est_time};
        end
        synchrocheck_pkg::ROT_TIME_OFFSET: begin
          rd = {15'h0000, rot_time};
        end
        synchrocheck_pkg::ANGLE_OFFSET: begin
          rd = {{12{state_reg.angle[synchrocheck_pkg::ANGLE_W-1]}},
            state_reg.angle};
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      state_next.rdata = rd;
      state_next.rresp = hit ? synchrocheck_pkg::RESP_OKAY :
        synchrocheck_pkg::RESP_SLVERR;
    end else if (s_axi_arvalid && !state_reg.rvalid) begin
      state_next.arready = 1'b1;
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.cfg <= synchrocheck_pkg::CONFIG_RESET;
      state_reg.brk_delay <= synchrocheck_pkg::BRK_DELAY_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  sync_rotation_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .tick(state_reg.tick),
    .angle(state_reg.angle),
    .rot_time(rot_time),
    .est_time(est_time)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign match_confirmed = state_reg.match_out;
  assign blocked = state_reg.blk_out;
  assign close_command = state_reg.close_cmd;
  assign line_is_measured = state_reg.line_ref;
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rresp = state_reg.rresp;
  assign s_axi_rdata = state_reg.rdata;

endmodule

// *** verification/breaker_model.sv ***
// Breaker objects that take the block's close commands.
// Assumes one-hot close pulses of one clock on the system clock.
`timescale 1ns/10ps
module breaker_model #(
  parameter int DELAY = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] close_command,
  output logic [4:0] closed_obj
);
  logic [4:0] pend;
  int cnt;

  // ----------------------------------------------------------------
  // Operating delay, then the commanded object reports closed
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend <= 5'h0;
      cnt <= 0;
      closed_obj <= 5'h0;
    end else if (|close_command) begin
      pend <= close_command;
      cnt <= DELAY;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        closed_obj <= pend;
      end
    end
  end
endmodule

// *** verification/sc_asserts.sv ***
// Port checker for the synchrocheck control block.
// Assumes a bind onto synchrocheck_control from the bench top.
`timescale 1ns/10ps
module sc_asserts #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] sync_ok_in,
  input wire logic [2:0] block_in,
  input wire logic [2:0] match_confirmed,
  input wire logic [2:0] blocked,
  input wire logic [4:0] close_command,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  int blk_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Cycles a match has stood against an active block
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || !(match_confirmed[0] && block_in[0])) begin
      blk_cnt <= 0;
    end else begin
      blk_cnt <= blk_cnt + 1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_match_cause: assert property (
    $rose(match_confirmed[0]) |-> $past(sync_ok_in[0] && !block_in[0]))
    else $error("match rose without unblocked sync");
  a_block_cause: assert property (
    $rose(blocked[0]) |-> $past(block_in[0] && sync_ok_in[0]))
    else $error("blocked rose without block and sync");
  a_match_excl: assert property (
    !(match_confirmed[0] && blocked[0]))
    else $error("match and blocked together");
  a_block_clears: assert property (
    blk_cnt <= TICK_CYCLES + 2)
    else $error("match kept under active block");
  a_close_onehot: assert property ($onehot0(close_command))
    else $error("close sent to several objects");
  a_close_pulse: assert property (
    |close_command |=> !(|close_command))
    else $error("close longer than one clock");
  a_close_match: assert property (
    |close_command |-> match_confirmed[0])
    else $error("close without stage one match");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");

  c_match: cover property ($rose(match_confirmed[0]));
  c_blocked: cover property ($rose(blocked[0]));
  c_close: cover property (|close_command);
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

// *** verification/tb_top.sv ***
// Bench top: drives the control block over AXI4-Lite and its pins.
// Assumes the breaker model and the checker are compiled first.
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end
module tb_top;
  localparam int TICKS = 20;
  localparam logic [7:0] CFG = synchrocheck_pkg::CONFIG_OFFSET;
  localparam logic [7:0] BRK = synchrocheck_pkg::BRK_DELAY_OFFSET;
  localparam logic [7:0] STS = synchrocheck_pkg::STATUS_OFFSET;
  localparam logic [7:0] ANG = synchrocheck_pkg::ANGLE_OFFSET;
  localparam logic [1:0] OK = synchrocheck_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = synchrocheck_pkg::RESP_SLVERR;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
  logic clk = 0, rst_n = 0, third_voltage_input = 0;
  logic fourth_voltage_input = 0, ll_only_wiring = 0;
  logic two_ll_aux_wiring = 0, line_is_measured;
  logic [2:0] sync_ok_in = 0, block_in = 0, stage_begin_input = 0;
  logic [2:0] match_confirmed, blocked;
  logic [4:0] close_command, closed_obj;
  logic [19:0] angle_diff = 0, v;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  note_t rq[$], n;
  logic [1:0] bq[$], br;
  int err_total = 0, n_checks = 0, seed = 57;

  synchrocheck_control #(.TICK_CYCLES(TICKS)) DUT (.clk, .rst_n,
    .sync_ok_in, .block_in, .angle_diff, .third_voltage_input,
    .fourth_voltage_input, .ll_only_wiring, .two_ll_aux_wiring,
    .stage_begin_input, .match_confirmed, .blocked, .close_command,
    .line_is_measured, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  breaker_model #(.DELAY(3)) u_brk (.clk, .rst_n, .close_command,
    .closed_obj);

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Bus tasks and response monitor
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] x,
      input logic [1:0] r);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do @(posedge clk); while (!s_axi_awready);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic [31:0] m, input logic [1:0] r);
    rq.push_back('{x, m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
      n = rq.pop_front();
      `CHK(s_axi_rdata & n.m, n.d & n.m)
      `CHK(s_axi_rresp, n.r)
    end
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
      br = bq.pop_front();
      `CHK(s_axi_bresp, br)
    end
  end

  task automatic tk();
    repeat (2 * TICKS + 4) @(posedge clk);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(CFG, 32'h0, 32'hFFFFFFFF, OK);
    rd(BRK, 32'hA, 32'hFFFFFFFF, OK);
    rd(8'h18, 32'h0, 32'hFFFFFFFF, ERR);
    wr(CFG, 32'h820, ERR);
    rd(STS, 32'h0, 32'h7F, OK);
    `CHK(line_is_measured, 1'h0)
    $display("test reset done");
    third_voltage_input <= 1'h1;
    sync_ok_in <= 3'h1;
    tk();
    rd(STS, 32'h40, 32'h7F, OK);
    wr(CFG, 32'h820, OK);
    tk();
    rd(STS, 32'h41, 32'h7F, OK);
    `CHK(match_confirmed, 3'h1)
    block_in <= 3'h1;
    tk();
    rd(STS, 32'h40, 32'h7F, OK);
    sync_ok_in <= 3'h0;
    tk();
    sync_ok_in <= 3'h1;
    tk();
    rd(STS, 32'h48, 32'h7F, OK);
    `CHK(blocked, 3'h1)
    $display("test blocking done");
    block_in <= 3'h0;
    sync_ok_in <= 3'h0;
    wr(CFG, 32'h920, OK);
    tk();
    sync_ok_in <= 3'h1;
    tk();
    rd(STS, 32'h40, 32'h7F, OK);
    stage_begin_input <= 3'h1;
    tk();
    rd(STS, 32'h41, 32'h7F, OK);
    $display("test start done");
    wr(BRK, 32'h7FFFF, OK);
    for (int k = 0; k < 5; k++) begin
      sync_ok_in <= 3'h0;
      wr(CFG, 32'h20820 | (32'(k) << 18), OK);
      tk();
      sync_ok_in <= 3'h1;
      tk();
      `CHK(closed_obj, 5'h1 << k)
    end
    $display("test close done");
    wr(CFG, 32'hC, OK);
    tk();
    rd(STS, 32'h0, 32'h3F, OK);
    wr(CFG, 32'hD, OK);
    tk();
    rd(STS, 32'h4, 32'h3F, OK);
    wr(CFG, 32'h10, OK);
    tk();
    `CHK(line_is_measured, 1'h1)
    v = 20'($random(seed));
    angle_diff <= v;
    tk();
    rd(ANG, {{12{v[19]}}, v}, 32'hFFFFFFFF, OK);
    d = $random(seed) & 32'h7FFFF;
    wr(BRK, d, OK);
    rd(BRK, d, 32'hFFFFFFFF, OK);
    for (int k = 0; k < 4; k++) begin
      angle_diff <= k[0] ? 20'h00000 : 20'h80000;
      repeat (2 * TICKS) @(posedge clk);
    end
    tk();
    rd(synchrocheck_pkg::ROT_TIME_OFFSET, 32'h4, 32'hFFFFFFFF, OK);
    tk();
    rd(synchrocheck_pkg::EST_CLOSE_OFFSET, 32'h0, 32'hFFFFFFFF, OK);
    fourth_voltage_input <= 1'h1;
    two_ll_aux_wiring <= 1'h1;
    ll_only_wiring <= 1'h1;
    sync_ok_in <= 3'h6;
    wr(CFG, 32'h160E0, OK);
    tk();
    rd(STS, 32'h346, 32'h7FF, OK);
    `CHK(match_confirmed, 3'h6)
    wr(STS, 32'h0, ERR);
    $display("test settings done");
    stop_test();
  end
endmodule

bind synchrocheck_control sc_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk, .rst_n, .sync_ok_in, .block_in, .match_confirmed, .blocked,
  .close_command, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid);
